// File: rtl/byte_bus_master.sv
// Byte-wide asynchronous bus cycle sequencer.
// Assumes synchronous inputs; one clock cycle stands for one half-state.
`timescale 1ns/100ps
module byte_bus_master (
  input  wire logic                      clock,
  input  wire logic                      nrst,
  input  wire logic                      widthSelect,       // Low at reset picks byte mode.
  input  wire logic                      reqValid,          // Core requests a transfer.
  input  byte_bus_pkg::core_req_t        req,               // Transfer description.
  output logic                           reqReady,          // Sequencer idle and enabled.
  output logic                           rspValid,          // One-cycle answer pulse.
  output byte_bus_pkg::core_rsp_t        rsp,               // Answer data and fault flag.
  output logic                           byteMode,          // Byte mode selected.
  output logic                           periphHandoff,     // Slow peripheral takes over.
  input  wire logic                      periphDone,        // Peripheral sequence finished.
  input  wire logic [7:0]                dataIn,            // Data bus input.
  input  wire logic                      transfer_ack_n,    // Slave acknowledge.
  input  wire logic                      bus_fault_n,       // Slave bus fault.
  input  wire logic                      slow_periph_sel_n, // Slow peripheral select.
  output byte_bus_pkg::bus_pins_t        pins               // Pins toward the slave.
);

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_RESET,
    ST_IDLE,
    ST_CYCLE,
    ST_PERIPH,
    ST_OFF
  } seq_state_t;

  seq_state_t                seq_ff, nxt_seq;          // Sequencer state.
  logic [4:0]                phase_ff, nxt_phase;      // Numbered half-state.
  logic [1:0]                byteIdx_ff, nxt_byteIdx;  // Byte within word or long.
  logic [1:0]                lastIdx_ff, nxt_lastIdx;  // Final byte index.
  logic                      modeSel_ff, nxt_modeSel;  // Caught width select, inverted.
  byte_bus_pkg::core_req_t   req_ff, nxt_req;          // Held request.
  logic [31:0]               rdata_ff, nxt_rdata;      // Assembled read data.
  logic [7:0]                latch_ff, nxt_latch;      // Byte latched in state six.
  logic                      fault_ff, nxt_fault;      // Fault seen in this cycle.
  logic                      ackSeen_ff, nxt_ackSeen;  // Acknowledge seen.
  logic                      rspValid_ff, nxt_rspValid; // Answer pulse.
  byte_bus_pkg::bus_pins_t   pins_ff, nxt_pins;        // Registered pins.
  logic                      isWrite, isAtomic;        // Decoded kind.
  logic [7:0]                wrByte;                   // Byte being written.

  // Returns the write byte, most significant first.
  function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic [1:0] last,
                                           input logic [1:0] idx);
    logic [1:0] sel;
    sel = last - idx;
    pick_byte = w[sel*8 +: 8];
  endfunction

  assign isWrite  = (req_ff.op == byte_bus_pkg::OP_WRITE);
  assign isAtomic = (req_ff.op == byte_bus_pkg::OP_ATOMIC);
  assign wrByte   = pick_byte(req_ff.wdata, lastIdx_ff, byteIdx_ff);

  // Next-state logic for the whole sequencer.
  always_comb begin
    nxt_seq      = seq_ff;
    nxt_phase    = phase_ff;
    nxt_byteIdx  = byteIdx_ff;
    nxt_lastIdx  = lastIdx_ff;
    nxt_modeSel  = modeSel_ff;
    nxt_req      = req_ff;
    nxt_rdata    = rdata_ff;
    nxt_latch    = latch_ff;
    nxt_fault    = fault_ff;
    nxt_ackSeen  = ackSeen_ff;
    nxt_rspValid = 1'b0;
    nxt_pins     = pins_ff;
    nxt_pins.highByteStrobeN = 1'b1;
    unique case (seq_ff)
      ST_RESET: begin
        // Mode is caught on the first edge after reset release.
        nxt_modeSel = ~widthSelect;
        nxt_seq     = widthSelect ? ST_OFF : ST_IDLE;
      end
      ST_OFF: begin
        // Wide mode: this sequencer stays parked.
        nxt_seq = ST_OFF;
      end
      ST_IDLE: begin
        if (reqValid) begin
          nxt_req = req;
          // Atomic transfers are forced to a single byte.
          if (req.op == byte_bus_pkg::OP_ATOMIC || req.size == byte_bus_pkg::SZ_BYTE) begin
            nxt_lastIdx = 2'h0;
          end else if (req.size == byte_bus_pkg::SZ_WORD) begin
            nxt_lastIdx = 2'h1;
          end else begin
            nxt_lastIdx = 2'h3;
          end
          nxt_byteIdx = 2'h0;
          nxt_rdata   = 32'h0000_0000;
          nxt_fault   = 1'b0;
          nxt_ackSeen = 1'b0;
          nxt_phase   = 5'h00;
          nxt_seq     = ST_CYCLE;
          // State zero: space code and read level.
          nxt_pins.spaceCode    = req.space;
          nxt_pins.readNotWrite = 1'b1;
        end
      end
      ST_PERIPH: begin
        // A separate peripheral sequence owns the bus now.
        if (periphDone) begin
          nxt_pins = byte_bus_pkg::PINS_IDLE;
          nxt_seq  = ST_IDLE;
          nxt_rspValid = 1'b1;
        end
      end
      ST_CYCLE: begin
        nxt_phase = phase_ff + 5'h01;
        case (phase_ff)
          5'h00: begin
            // Entering state one: drive the address plus the byte index.
            nxt_pins.addr   = req_ff.addr + byte_bus_pkg::ADDR_W'(byteIdx_ff);
            nxt_pins.addrOe = 1'b1;
          end
          5'h01: begin
            // Rising edge of state two: strobes.
            nxt_pins.addrStrobeN = 1'b0;
            if (isWrite) begin
              nxt_pins.readNotWrite = 1'b0;
            end else begin
              nxt_pins.lowByteStrobeN = 1'b0;
            end
          end
          5'h02: begin
            // State three: write byte onto the bus.
            if (isWrite) begin
              nxt_pins.dataOut = wrByte;
              nxt_pins.dataOe  = 1'b1;
            end
          end
          5'h03, 5'h0F: begin
            // Rising edge of state four or sixteen: data strobe for writes.
            nxt_pins.lowByteStrobeN = 1'b0;
          end
          5'h04, 5'h10: begin
            // End of state four or sixteen: sample termination inputs.
            if (!slow_periph_sel_n && transfer_ack_n && bus_fault_n) begin
              nxt_seq = ST_PERIPH;
            end else if (!transfer_ack_n) begin
              nxt_ackSeen = 1'b1;
            end else if (!bus_fault_n) begin
              nxt_fault = 1'b1;
            end else begin
              nxt_phase = phase_ff;
            end
          end
          5'h05, 5'h06, 5'h07, 5'h08, 5'h11, 5'h12: begin
            // Fault sampling continues on the edges after state four or sixteen.
            if (!bus_fault_n && !ackSeen_ff) begin
              nxt_fault = 1'b1;
            end
            if (phase_ff == 5'h05 && !isWrite) begin
              nxt_latch = dataIn;
            end
            if (phase_ff == 5'h06 || phase_ff == 5'h12) begin
              // Entering state seven or nineteen.
              if (isAtomic && phase_ff == 5'h06) begin
                nxt_pins.lowByteStrobeN = 1'b1;
                nxt_rdata = {24'h000000, latch_ff};
              end else begin
                nxt_pins.addrStrobeN    = 1'b1;
                nxt_pins.lowByteStrobeN = 1'b1;
                if (!isWrite) begin
                  nxt_rdata = {rdata_ff[23:0], latch_ff};
                end
              end
            end
            if (phase_ff == byte_bus_pkg::ST_LAST_BASIC && isAtomic) begin
              nxt_phase = phase_ff + 5'h01;
            end else if (phase_ff == byte_bus_pkg::ST_LAST_BASIC
                         && fault_ff && !ackSeen_ff) begin
              nxt_phase = phase_ff + 5'h01;
            end else if (phase_ff == byte_bus_pkg::ST_LAST_BASIC
                         || phase_ff == byte_bus_pkg::ST_RMW_LAST) begin
              nxt_phase = 5'h14;
            end else if (phase_ff == 5'h08 && !isAtomic) begin
              nxt_phase = 5'h14;
            end
          end
          5'h09, 5'h0A, 5'h0B, 5'h0C: begin
            // States nine to twelve hold every pin.
            nxt_pins = pins_ff;
          end
          5'h0D: begin
            // Rising edge of state fourteen: write level.
            nxt_pins.readNotWrite = 1'b0;
          end
          5'h0E: begin
            // State fifteen: drive the modified byte.
            nxt_pins.dataOut = latch_ff | 8'h80;
            nxt_pins.dataOe  = 1'b1;
          end
          5'h13: begin
            // End of state nineteen: go on to the end of the byte cycle.
            nxt_phase = 5'h14;
          end
          default: begin
            // End of a byte cycle: float buses, restore read level.
            nxt_pins.addrOe       = 1'b0;
            nxt_pins.dataOe       = 1'b0;
            nxt_pins.readNotWrite = 1'b1;
            nxt_pins.addrStrobeN  = 1'b1;
            nxt_pins.lowByteStrobeN = 1'b1;
            nxt_ackSeen = 1'b0;
            if (fault_ff || byteIdx_ff == lastIdx_ff) begin
              nxt_seq      = ST_IDLE;
              nxt_rspValid = 1'b1;
            end else begin
              nxt_byteIdx = byteIdx_ff + 2'h1;
              nxt_phase   = 5'h00;
            end
          end
        endcase
      end
      default: begin
        nxt_seq = ST_IDLE;
      end
    endcase
  end

  // Registers of the sequencer.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      seq_ff      <= ST_RESET;
      phase_ff    <= 5'h00;
      byteIdx_ff  <= 2'h0;
      lastIdx_ff  <= 2'h0;
      modeSel_ff  <= 1'b0;
      req_ff      <= '0;
      rdata_ff    <= 32'h0000_0000;
      latch_ff    <= 8'h00;
      fault_ff    <= 1'b0;
      ackSeen_ff  <= 1'b0;
      rspValid_ff <= 1'b0;
      pins_ff     <= byte_bus_pkg::PINS_IDLE;
    end else begin
      seq_ff      <= nxt_seq;
      phase_ff    <= nxt_phase;
      byteIdx_ff  <= nxt_byteIdx;
      lastIdx_ff  <= nxt_lastIdx;
      modeSel_ff  <= nxt_modeSel;
      req_ff      <= nxt_req;
      rdata_ff    <= nxt_rdata;
      latch_ff    <= nxt_latch;
      fault_ff    <= nxt_fault;
      ackSeen_ff  <= nxt_ackSeen;
      rspValid_ff <= nxt_rspValid;
      pins_ff     <= nxt_pins;
    end
  end

  // Outputs.
  assign reqReady      = (seq_ff == ST_IDLE);
  assign rspValid      = rspValid_ff;
  assign rsp.fault     = fault_ff;
  assign rsp.rdata     = rdata_ff;
  assign byteMode      = modeSel_ff;
  assign periphHandoff = (seq_ff == ST_PERIPH);
  assign pins          = pins_ff;

endmodule

// File: rtl/byte_bus_pkg.sv
// Constants, types and named half-states for the byte-wide bus sequencer.
// Assumes one 25 MHz clock; each bus half-state lasts one clock cycle.
package byte_bus_pkg;

  localparam int ADDR_W = 22;          // Byte address width.

  // Transfer sizes requested by the core.
  typedef enum logic [1:0] {
    SZ_BYTE,
    SZ_WORD,
    SZ_LONG
  } xfer_size_t;

  // Kinds of transfer requested by the core.
  typedef enum logic [1:0] {
    OP_READ,
    OP_WRITE,
    OP_ATOMIC
  } xfer_op_t;

  // Space codes driven on the three code outputs.
  localparam logic [2:0] SPACE_USER_DATA = 3'h1;
  localparam logic [2:0] SPACE_USER_PROG = 3'h2;
  localparam logic [2:0] SPACE_SUPV_DATA = 3'h5;
  localparam logic [2:0] SPACE_SUPV_PROG = 3'h6;
  localparam logic [2:0] SPACE_PROC      = 3'h7;

  // Request from the core.
  typedef struct packed {
    xfer_op_t             op;
    xfer_size_t           size;
    logic [2:0]           space;
    logic [ADDR_W-1:0]    addr;
    logic [31:0]          wdata;
  } core_req_t;

  // Answer to the core.
  typedef struct packed {
    logic        fault;
    logic [31:0] rdata;
  } core_rsp_t;

  // Pins toward the far side.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              addrOe;
    logic [7:0]        dataOut;
    logic              dataOe;
    logic              addrStrobeN;
    logic              lowByteStrobeN;
    logic              highByteStrobeN;
    logic              readNotWrite;
    logic [2:0]        spaceCode;
  } bus_pins_t;

  // Reset value of the pin bundle: idle, released.
  localparam bus_pins_t PINS_IDLE = '{addr: '0, addrOe: 1'b0, dataOut: 8'h00,
    dataOe: 1'b0, addrStrobeN: 1'b1, lowByteStrobeN: 1'b1,
    highByteStrobeN: 1'b1, readNotWrite: 1'b1, spaceCode: 3'h0};

  // Named half-states in numeric order.
  localparam logic [4:0] ST_LAST_BASIC = 5'h07;
  localparam logic [4:0] ST_FAULT_END  = 5'h09;
  localparam logic [4:0] ST_RMW_WRITE  = 5'h0C;
  localparam logic [4:0] ST_RMW_LAST   = 5'h13;

endpackage

// File: verification/bus_slave_model.sv
// Behavioural byte-wide memory slave on the far side of the sequencer.
// Assumes the bench sets wait count, fault and slow-peripheral modes.
`timescale 1ns/100ps
module bus_slave_model (
  input wire logic                     clock,
  input wire byte_bus_pkg::bus_pins_t  pins,
  input wire logic [3:0]               waitCycles,  // Cycles before answering.
  input wire logic                     faultMode,   // Answer with a bus fault.
  input wire logic                     slowMode,    // Claim to be a slow peripheral.
  output logic [7:0]                   dataIn,
  output logic                         ackN,
  output logic                         faultN,
  output logic                         slowN
);
  logic [7:0] mem [256];  // Contents start as address xor 5A.
  logic [7:0] lastData;   // Last byte driven, inverted when released.
  logic [3:0] cnt;        // Wait cycles counted so far.

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
    lastData = 8'h00;
    cnt = 4'h0;
    ackN = 1'b1;
    faultN = 1'b1;
  end

  // Read data only while selected for a read; otherwise a changed value.
  assign dataIn = (!pins.lowByteStrobeN && pins.readNotWrite) ?
                  mem[pins.addr[7:0]] : ~lastData;
  assign slowN = !(slowMode && !pins.lowByteStrobeN);

  // Answer after the wait count; hold it until the strobe goes away.
  always @(posedge clock) begin
    lastData <= dataIn;
    if (pins.lowByteStrobeN) begin
      cnt <= 4'h0;
      ackN <= 1'b1;
      faultN <= 1'b1;
    end else if (cnt < waitCycles) begin
      cnt <= cnt + 4'h1;
    end else if (faultMode) begin
      faultN <= 1'b0;
    end else if (!slowMode) begin
      ackN <= 1'b0;
      if (!pins.readNotWrite && ackN) mem[pins.addr[7:0]] <= pins.dataOut;
    end
  end
endmodule

// File: verification/byte_bus_master_props.sv
// Pin-level checker for the byte-wide bus sequencer.
// Assumes it is bound to byte_bus_master and sees its ports only.
`timescale 1ns/100ps
module byte_bus_master_props (
  input wire logic                     clock,
  input wire logic                     nrst,
  input wire logic                     reqReady,
  input wire logic                     rspValid,
  input wire logic                     byteMode,
  input wire logic                     transfer_ack_n,
  input wire logic                     bus_fault_n,
  input wire logic                     slow_periph_sel_n,
  input wire byte_bus_pkg::bus_pins_t  pins
);
  // All checks run on the one clock and sleep through reset.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  property p_highQuiet; pins.highByteStrobeN; endproperty
  a_highQuiet: assert property (p_highQuiet) else $error("high strobe asserted");
  property p_readyMode; reqReady |-> byteMode; endproperty
  a_readyMode: assert property (p_readyMode) else $error("ready outside byte mode");
  property p_strobeInAs; !pins.lowByteStrobeN |-> !pins.addrStrobeN; endproperty
  a_strobeInAs: assert property (p_strobeInAs) else $error("strobe without address");
  property p_addrOut; !pins.addrStrobeN |-> pins.addrOe; endproperty
  a_addrOut: assert property (p_addrOut) else $error("address floats under strobe");
  property p_dataDir; pins.dataOe |-> !pins.readNotWrite; endproperty
  a_dataDir: assert property (p_dataDir) else $error("data driven while reading");
  // A strobe with no answer pending must be held into the next cycle.
  property p_waitHold;
    !pins.lowByteStrobeN && transfer_ack_n && bus_fault_n && slow_periph_sel_n
      |=> !pins.lowByteStrobeN;
  endproperty
  a_waitHold: assert property (p_waitHold) else $error("strobe dropped unanswered");
  property p_addrHold; !pins.addrStrobeN && !$past(pins.addrStrobeN) |-> $stable(pins.addr);
  endproperty
  a_addrHold: assert property (p_addrHold) else $error("address moved in cycle");
  property p_codeHold;
    !pins.addrStrobeN && !$past(pins.addrStrobeN) |-> $stable(pins.spaceCode);
  endproperty
  a_codeHold: assert property (p_codeHold) else $error("space code moved");
  property p_rspPulse; rspValid |-> pins.addrStrobeN ##1 !rspValid; endproperty
  a_rspPulse: assert property (p_rspPulse) else $error("answer not a clean pulse");

  // Main scenarios seen at the pins.
  c_read: cover property ($fell(pins.lowByteStrobeN) && pins.readNotWrite);
  c_write: cover property (pins.dataOe);
  c_fault: cover property ($fell(bus_fault_n));
endmodule

bind byte_bus_master byte_bus_master_props chk_u (.clock(clock), .nrst(nrst),
  .reqReady(reqReady), .rspValid(rspValid), .byteMode(byteMode),
  .transfer_ack_n(transfer_ack_n), .bus_fault_n(bus_fault_n),
  .slow_periph_sel_n(slow_periph_sel_n), .pins(pins));

// File: verification/byte_bus_master_tb.sv
// Self-checking bench for the byte-wide bus sequencer.
// Assumes the slave model and the bound pin checker.
`timescale 1ns/100ps
`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
  $display("BAD %s expected %0h seen %0h", what, exp, got); end end
module byte_bus_master_tb;
  localparam byte_bus_pkg::xfer_op_t RD = byte_bus_pkg::OP_READ;
  localparam byte_bus_pkg::xfer_op_t WR = byte_bus_pkg::OP_WRITE;
  localparam byte_bus_pkg::xfer_op_t AT = byte_bus_pkg::OP_ATOMIC;
  localparam byte_bus_pkg::xfer_size_t BY = byte_bus_pkg::SZ_BYTE;
  localparam byte_bus_pkg::xfer_size_t WD = byte_bus_pkg::SZ_WORD;
  localparam byte_bus_pkg::xfer_size_t LG = byte_bus_pkg::SZ_LONG;
  // One request with its expected answer.
  typedef struct packed {
    byte_bus_pkg::xfer_op_t op; byte_bus_pkg::xfer_size_t size; logic [7:0] addr;
    logic [31:0] wdata; logic [3:0] waits; logic fault; logic [31:0] exp;
  } row_t;
  logic clock = 0, nrst = 0, widthSelect = 0, reqValid = 0, periphDone = 0;
  logic faultMode = 0, slowMode = 0, reqReady, rspValid, byteMode, periphHandoff;
  logic ackN, faultN, slowN;
  logic [7:0] dataIn;
  logic [3:0] waitCycles = 4'h0;
  byte_bus_pkg::core_req_t req = '0;
  byte_bus_pkg::core_rsp_t rsp;
  byte_bus_pkg::bus_pins_t pins;
  int fail_count = 0, checks_done = 0, n;
  row_t rows [10] = '{
    '{RD, BY, 8'h05, 32'h0, 4'h0, 1'b0, 32'h5F}, '{RD, WD, 8'h10, 32'h0, 4'h2, 1'b0, 32'h4A4B},
    '{RD, LG, 8'h14, 32'h0, 4'h1, 1'b0, 32'h4E4F4C4D},
    '{WR, WD, 8'h20, 32'hBEEF, 4'h0, 1'b0, 32'h0}, '{RD, WD, 8'h20, 32'h0, 4'h3, 1'b0, 32'hBEEF},
    '{WR, LG, 8'h24, 32'h1234ABCD, 4'h0, 1'b0, 32'h0},
    '{RD, LG, 8'h24, 32'h0, 4'h0, 1'b0, 32'h1234ABCD},
    '{AT, BY, 8'h30, 32'h0, 4'h1, 1'b0, 32'h6A}, '{RD, BY, 8'h30, 32'h0, 4'h0, 1'b0, 32'hEA},
    '{RD, BY, 8'h40, 32'h0, 4'h1, 1'b1, 32'h0}};

  always #20 clock = ~clock;

  byte_bus_master dut_u (.clock(clock), .nrst(nrst), .widthSelect(widthSelect),
    .reqValid(reqValid), .req(req), .reqReady(reqReady), .rspValid(rspValid), .rsp(rsp),
    .byteMode(byteMode), .periphHandoff(periphHandoff), .periphDone(periphDone),
    .dataIn(dataIn), .transfer_ack_n(ackN), .bus_fault_n(faultN),
    .slow_periph_sel_n(slowN), .pins(pins));
  bus_slave_model slave_u (.clock(clock), .pins(pins), .waitCycles(waitCycles),
    .faultMode(faultMode), .slowMode(slowMode), .dataIn(dataIn), .ackN(ackN),
    .faultN(faultN), .slowN(slowN));

  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Waits on falling edges until the flag is high, at most 300 cycles.
  task automatic wait_high(ref logic flag);
    n = 0;
    do begin @(negedge clock); n++; end while (flag !== 1'b1 && n < 300);
  endtask

  // Issues one request and checks the answer against the row.
  task run_req(input row_t r);
    logic [31:0] mask;
    @(posedge clock); #1;
    faultMode = r.fault;
    waitCycles = r.waits;
    req = '{op: r.op, size: r.size, space: byte_bus_pkg::SPACE_USER_DATA,
            addr: {14'h0, r.addr}, wdata: r.wdata};
    reqValid = 1;
    wait_high(reqReady);
    @(posedge clock); #1 reqValid = 0;
    wait_high(rspValid);
    `CHK("answer", 1'b1, rspValid)
    `CHK("fault", r.fault, rsp.fault)
    mask = r.size == BY ? 32'hFF : r.size == WD ? 32'hFFFF : 32'hFFFFFFFF;
    if (!r.fault && r.op != WR) `CHK("rdata", r.exp, rsp.rdata & mask)
  endtask

  // Table rows, then hand-off, reset and wide-mode cases.
  initial begin
    repeat (6) @(posedge clock);
    #1 nrst = 1;
    foreach (rows[i]) begin run_req(rows[i]); $display("row %0d done", i); end
    @(posedge clock); #1 slowMode = 1; faultMode = 0; reqValid = 1;
    wait_high(reqReady);
    @(posedge clock); #1 reqValid = 0;
    wait_high(periphHandoff);
    `CHK("handoff", 1'b1, periphHandoff)
    @(posedge clock); #1 periphDone = 1;
    @(posedge clock); #1 periphDone = 0;
    wait_high(reqReady);
    `CHK("ready after handoff", 1'b1, reqReady)
    slowMode = 0;
    $display("handoff test done");
    @(posedge clock); #1 nrst = 0; widthSelect = 1;
    repeat (2) @(negedge clock);
    `CHK("strobe idle", 1'b1, pins.addrStrobeN)
    `CHK("read level idle", 1'b1, pins.readNotWrite)
    @(posedge clock); #1 nrst = 1;
    repeat (10) @(negedge clock);
    `CHK("wide ready", 1'b0, reqReady)
    `CHK("wide mode", 1'b0, byteMode)
    @(posedge clock); #1 nrst = 0; widthSelect = 0;
    repeat (6) @(posedge clock);
    #1 nrst = 1;
    // The slave keeps its contents over reset, so the modified byte reads back.
    run_req(rows[8]);
    $display("reset test done");
    tally_and_finish();
  end

  // Cuts a hang short well past the expected few hundred cycles.
  initial begin
    #2000000;
    fail_count++;
    tally_and_finish();
  end
endmodule
